// ==== src/rie_regs.vh ====
// Purpose : Constants for the instruction execute block
// Assumes : Included by rie_core.v only
// Notes   : Opcode is instruction bits 15:8, operand bits 7:0; jump and call use bits 15:10 and target 9:0
`ifndef RIE_REGS_VH
`define RIE_REGS_VH
// ----------------------------------------
// Bus register byte offsets
// ----------------------------------------
`define RIE_A_CTRL    8'h00
`define RIE_A_STAT    8'h04
`define RIE_A_PMADR   8'h08
`define RIE_A_PMDAT   8'h0C
`define RIE_A_DMADR   8'h10
`define RIE_A_DMDAT   8'h14
`define RIE_CTRL_RUN  0
`define RIE_CTRL_WAKE 1
// ----------------------------------------
// Special data memory locations
// ----------------------------------------
`define RIE_M_TBLP    5'h00
`define RIE_M_TBPG    5'h01
`define RIE_M_PCLOW   5'h02
`define RIE_M_STAT    5'h03
`define RIE_M_TUB     5'h04
`define RIE_M_INTC    5'h05
`define RIE_TBPG_SEL  7
// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define RIE_F_C       0
`define RIE_F_HC      1
`define RIE_F_Z       2
`define RIE_F_SR      3
`define RIE_F_SLP     4
`define RIE_F_WDT     5
// ----------------------------------------
// Timing, reset, table page and decimal adjust values
// ----------------------------------------
`define RIE_PH_LAST   2'h3
`define RIE_LAST_PAGE 2'h3
`define RIE_PC_RST    10'h000
`define RIE_BCD_SIX   4'h6
`define RIE_BCD_NINE  4'h9
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define RIE_OP_NOP    8'h00
`define RIE_OP_RET    8'h01
`define RIE_OP_IRET   8'h02
`define RIE_OP_WKICK  8'h03
`define RIE_OP_HALT   8'h04
`define RIE_OP_ADD    8'h10
`define RIE_OP_ADDM   8'h11
`define RIE_OP_ADC    8'h12
`define RIE_OP_ADCM   8'h13
`define RIE_OP_SUB    8'h14
`define RIE_OP_SUBM   8'h15
`define RIE_OP_SUBB   8'h16
`define RIE_OP_SUBBM  8'h17
`define RIE_OP_BCD    8'h18
`define RIE_OP_AND    8'h19
`define RIE_OP_OR     8'h1A
`define RIE_OP_XOR    8'h1B
`define RIE_OP_ANDM   8'h1C
`define RIE_OP_ORM    8'h1D
`define RIE_OP_XORM   8'h1E
`define RIE_OP_INV    8'h20
`define RIE_OP_INVA   8'h21
`define RIE_OP_INC    8'h22
`define RIE_OP_INCA   8'h23
`define RIE_OP_DEC    8'h24
`define RIE_OP_DECA   8'h25
`define RIE_OP_ROR    8'h26
`define RIE_OP_RORA   8'h27
`define RIE_OP_RORC   8'h28
`define RIE_OP_RORCA  8'h29
`define RIE_OP_ROL    8'h2A
`define RIE_OP_ROLA   8'h2B
`define RIE_OP_ROLC   8'h2C
`define RIE_OP_ROLCA  8'h2D
`define RIE_OP_SWAP   8'h2E
`define RIE_OP_SWAPA  8'h2F
`define RIE_OP_MOVAM  8'h30
`define RIE_OP_MOVMA  8'h31
`define RIE_OP_CLRM   8'h32
`define RIE_OP_SETM   8'h33
`define RIE_OP_SKZ    8'h34
`define RIE_OP_SKZA   8'h35
`define RIE_OP_INCSK  8'h36
`define RIE_OP_INCSKA 8'h37
`define RIE_OP_DECSK  8'h38
`define RIE_OP_DECSKA 8'h39
`define RIE_OP_TBRD   8'h3A
`define RIE_OP_TBRDF  8'h3B
`define RIE_OP_ADDX   8'h40
`define RIE_OP_SUBX   8'h41
`define RIE_OP_ANDX   8'h42
`define RIE_OP_ORX    8'h43
`define RIE_OP_XORX   8'h44
`define RIE_OP_MOVX   8'h45
`define RIE_OP_RETX   8'h46
`define RIE_OP_IMM    4'h4
`define RIE_OP_BCLR   5'h09
`define RIE_OP_BSET   5'h0A
`define RIE_OP_BSK0   5'h0B
`define RIE_OP_BSK1   5'h0C
`define RIE_OP_JMP    6'h3C
`define RIE_OP_CALL   6'h3D
`endif

// ==== src/rie_core.v ====
// Purpose : Execute unit of a small 8-bit accumulator core
// Assumes : Program and data memory are loaded over Wishbone while stopped
// Notes   : One instruction cycle is four mclk cycles
// Function
// RULE1 - Conditional skip takes one cycle without skip, two with skip
// RULE2 - Writing the program counter low byte takes two cycles
// RULE3 - Jump, call, returns take two cycles, no flag change
// RULE4 - Paged table read loads upper byte and memory byte, two cycles
// RULE5 - Final-page table read does the same from the last page
// RULE6 - Add with carry writes work register or memory, updates four flags
// RULE7 - Plain add of immediate or memory byte, updates four flags
// RULE8 - Subtract, optional borrow, updates four flags
// RULE9 - Decimal adjust stores in memory, changes only carry
// RULE10 - AND, OR, XOR into work register update only zero
// RULE11 - Memory forms of AND, OR, XOR write byte, update only zero
// RULE12 - Invert to memory or work register, updates zero
// RULE13 - Increment, decrement to memory or work register, zero only
// RULE14 - Plain rotates wrap one bit, no flag change
// RULE15 - Rotates through carry are nine bit, update only carry
// RULE16 - Moves take one cycle and change no flag
// RULE17 - Bit set and clear touch only bit 0 to 7 selected
// RULE18 - Skip group tests zero, bit states, inc or dec result
// RULE19 - Zero test with move also copies byte into work register
// RULE20 - Nibble swap to memory or work register, no flag change
// RULE21 - Power down takes one cycle, updates both watchdog flags
// RULE22 - Decimal adjust adds six per nibble above nine or carried
// RULE23 - Watchdog kick clears counter and both watchdog flags
// RULE24 - Interrupt return sets master enable, plain return does not
// RULE25 - Instruction cycle is four clocks
// RULE26 - All other instructions take one cycle
// RULE27 - Whole-byte clear and set write zeros or ones, no flag change
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "rie_regs.vh"

module rie_core (
   input  wire        mclk,
   input  wire        rst_b,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        wdt_expired,
   output reg         wdt_clear,
   output reg         sleep
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg [15:0] pmem [0:1023];
   reg [7:0]  dmem [0:31];
   reg [9:0]  pc;
   reg [9:0]  stk0;
   reg [9:0]  stk1;
   reg [1:0]  phase;
   reg        bubble;
   reg        run;
   reg [7:0]  work_register;
   reg [7:0]  table_upper_byte;
   reg [7:0]  tbl_ptr;
   reg [7:0]  tbl_page;
   reg        carry_flag;
   reg        half_carry_flag;
   reg        zero_flag;
   reg        signed_range_flag;
   reg        sleep_entered_flag;
   reg        wdt_expiry_flag;
   reg        master_irq_enable;
   reg [9:0]  pm_ptr;
   reg [4:0]  dm_ptr;

   // ----------------------------------------
   // Decode and datapath
   // ----------------------------------------
   reg [15:0] inst;
   reg [7:0]  op;
   reg [4:0]  ma;
   reg [7:0]  mv;
   reg [7:0]  opb;
   reg [7:0]  bb;
   reg        sub;
   reg        ci;
   reg [8:0]  s9;
   reg [4:0]  s5;
   reg [7:0]  res;
   reg [7:0]  bmask;
   reg [8:0]  d9;
   reg        adj_lo;
   reg        adj_hi;
   reg        wa;
   reg        wm;
   reg        uz;
   reg        uc;
   reg        uao;
   reg        nc;
   reg        skp;
   reg        jmp;
   reg        push;
   reg        pop;
   reg        iret;
   reg        tbl;
   reg        kick;
   reg        halt;
   reg [9:0]  taddr;
   reg [15:0] tword;
   reg [9:0]  pc1;
   reg [9:0]  next_pc;
   reg        next_bubble;
   reg [7:0]  stat_byte;
   reg [7:0]  rdm;

   wire       exe = run & ~sleep & (phase == `RIE_PH_LAST);
   wire       bus = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       pcl_wr = wm & (ma == `RIE_M_PCLOW);

   always @* begin
      stat_byte = 8'h00;
      stat_byte[`RIE_F_C] = carry_flag;
      stat_byte[`RIE_F_HC] = half_carry_flag;
      stat_byte[`RIE_F_Z] = zero_flag;
      stat_byte[`RIE_F_SR] = signed_range_flag;
      stat_byte[`RIE_F_SLP] = sleep_entered_flag;
      stat_byte[`RIE_F_WDT] = wdt_expiry_flag;
   end

   // Special locations shadow the array entries at the same address
   always @* begin
      inst = pmem[pc];
      op = inst[15:8];
      ma = inst[4:0];
      case (ma)
         `RIE_M_TBLP:  mv = tbl_ptr;
         `RIE_M_TBPG:  mv = tbl_page;
         `RIE_M_PCLOW: mv = pc[7:0];
         `RIE_M_STAT:  mv = stat_byte;
         `RIE_M_TUB:   mv = table_upper_byte;
         `RIE_M_INTC:  mv = {7'h00, master_irq_enable};
         default:      mv = dmem[ma];
      endcase
      rdm = dmem[dm_ptr];
   end

   always @* begin
      opb = (op[7:4] == `RIE_OP_IMM) ? inst[7:0] : mv;
      sub = (op == `RIE_OP_SUB) | (op == `RIE_OP_SUBM) | (op == `RIE_OP_SUBX)
          | (op == `RIE_OP_SUBB) | (op == `RIE_OP_SUBBM);
      if ((op == `RIE_OP_ADC) | (op == `RIE_OP_ADCM)
          | (op == `RIE_OP_SUBB) | (op == `RIE_OP_SUBBM))
         ci = carry_flag;
      else
         ci = sub;
      // Subtract is add of the complement; carry set means no borrow
      bb = sub ? ~opb : opb;
      s9 = {1'b0, work_register} + {1'b0, bb} + {8'h00, ci};
      s5 = {1'b0, work_register[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
      adj_lo = (work_register[3:0] > `RIE_BCD_NINE) | half_carry_flag; // RULE22
      adj_hi = (work_register[7:4] > `RIE_BCD_NINE) | carry_flag; // RULE22
      d9 = {1'b0, work_register}
         + {1'b0, (adj_hi ? `RIE_BCD_SIX : 4'h0), (adj_lo ? `RIE_BCD_SIX : 4'h0)};
      bmask = 8'h01 << op[2:0];
      if (op == `RIE_OP_TBRDF)
         taddr = {`RIE_LAST_PAGE, tbl_ptr}; // RULE5
      else if (tbl_page[`RIE_TBPG_SEL])
         taddr = {tbl_page[1:0], tbl_ptr}; // RULE4
      else
         taddr = {pc[9:8], tbl_ptr}; // RULE4
      tword = pmem[taddr];
   end

   always @* begin
      res = 8'h00;
      wa = 1'b0;
      wm = 1'b0;
      uz = 1'b0;
      uc = 1'b0;
      uao = 1'b0;
      nc = carry_flag;
      skp = 1'b0;
      jmp = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      iret = 1'b0;
      tbl = 1'b0;
      kick = 1'b0;
      halt = 1'b0;
      case (op)
         `RIE_OP_ADD, `RIE_OP_ADDX, `RIE_OP_ADC: begin
            res = s9[7:0]; wa = 1'b1; uz = 1'b1; uc = 1'b1; uao = 1'b1; // RULE6 RULE7
         end
         `RIE_OP_ADDM, `RIE_OP_ADCM: begin
            res = s9[7:0]; wm = 1'b1; uz = 1'b1; uc = 1'b1; uao = 1'b1; // RULE6 RULE7
         end
         `RIE_OP_SUB, `RIE_OP_SUBX, `RIE_OP_SUBB: begin
            res = s9[7:0]; wa = 1'b1; uz = 1'b1; uc = 1'b1; uao = 1'b1; // RULE8
         end
         `RIE_OP_SUBM, `RIE_OP_SUBBM: begin
            res = s9[7:0]; wm = 1'b1; uz = 1'b1; uc = 1'b1; uao = 1'b1; // RULE8
         end
         `RIE_OP_BCD: begin
            res = d9[7:0]; wm = 1'b1; uc = 1'b1; nc = d9[8] | adj_hi; // RULE9
         end
         `RIE_OP_AND, `RIE_OP_ANDX: begin
            res = work_register & opb; wa = 1'b1; uz = 1'b1; // RULE10
         end
         `RIE_OP_OR, `RIE_OP_ORX: begin
            res = work_register | opb; wa = 1'b1; uz = 1'b1; // RULE10
         end
         `RIE_OP_XOR, `RIE_OP_XORX: begin
            res = work_register ^ opb; wa = 1'b1; uz = 1'b1; // RULE10
         end
         `RIE_OP_ANDM: begin
            res = work_register & mv; wm = 1'b1; uz = 1'b1; // RULE11
         end
         `RIE_OP_ORM: begin
            res = work_register | mv; wm = 1'b1; uz = 1'b1; // RULE11
         end
         `RIE_OP_XORM: begin
            res = work_register ^ mv; wm = 1'b1; uz = 1'b1; // RULE11
         end
         `RIE_OP_INV, `RIE_OP_INVA: begin
            res = ~mv; wm = ~op[0]; wa = op[0]; uz = 1'b1; // RULE12
         end
         `RIE_OP_INC, `RIE_OP_INCA: begin
            res = mv + 8'h01; wm = ~op[0]; wa = op[0]; uz = 1'b1; // RULE13
         end
         `RIE_OP_DEC, `RIE_OP_DECA: begin
            res = mv - 8'h01; wm = ~op[0]; wa = op[0]; uz = 1'b1; // RULE13
         end
         `RIE_OP_ROR, `RIE_OP_RORA: begin
            res = {mv[0], mv[7:1]}; wm = ~op[0]; wa = op[0]; // RULE14
         end
         `RIE_OP_ROL, `RIE_OP_ROLA: begin
            res = {mv[6:0], mv[7]}; wm = ~op[0]; wa = op[0]; // RULE14
         end
         `RIE_OP_RORC, `RIE_OP_RORCA: begin
            res = {carry_flag, mv[7:1]}; nc = mv[0]; uc = 1'b1; // RULE15
            wm = ~op[0]; wa = op[0];
         end
         `RIE_OP_ROLC, `RIE_OP_ROLCA: begin
            res = {mv[6:0], carry_flag}; nc = mv[7]; uc = 1'b1; // RULE15
            wm = ~op[0]; wa = op[0];
         end
         `RIE_OP_SWAP, `RIE_OP_SWAPA: begin
            res = {mv[3:0], mv[7:4]}; wm = ~op[0]; wa = op[0]; // RULE20
         end
         `RIE_OP_MOVAM: begin
            res = mv; wa = 1'b1; // RULE16
         end
         `RIE_OP_MOVMA: begin
            res = work_register; wm = 1'b1; // RULE16
         end
         `RIE_OP_MOVX: begin
            res = inst[7:0]; wa = 1'b1; // RULE16
         end
         `RIE_OP_CLRM: begin
            res = 8'h00; wm = 1'b1; // RULE27
         end
         `RIE_OP_SETM: begin
            res = 8'hFF; wm = 1'b1; // RULE27
         end
         `RIE_OP_SKZ: begin
            skp = (mv == 8'h00); // RULE18
         end
         `RIE_OP_SKZA: begin
            res = mv; wa = 1'b1; skp = (mv == 8'h00); // RULE19
         end
         `RIE_OP_INCSK, `RIE_OP_INCSKA: begin
            res = mv + 8'h01; wm = ~op[0]; wa = op[0]; // RULE18
            skp = (res == 8'h00);
         end
         `RIE_OP_DECSK, `RIE_OP_DECSKA: begin
            res = mv - 8'h01; wm = ~op[0]; wa = op[0]; // RULE18
            skp = (res == 8'h00);
         end
         `RIE_OP_TBRD, `RIE_OP_TBRDF: begin
            res = tword[7:0]; wm = 1'b1; tbl = 1'b1; // RULE4 RULE5
         end
         `RIE_OP_RET: begin
            pop = 1'b1; // RULE3 RULE24
         end
         `RIE_OP_IRET: begin
            pop = 1'b1; iret = 1'b1; // RULE3 RULE24
         end
         `RIE_OP_RETX: begin
            pop = 1'b1; res = inst[7:0]; wa = 1'b1; // RULE3
         end
         `RIE_OP_WKICK: begin
            kick = 1'b1; // RULE23
         end
         `RIE_OP_HALT: begin
            kick = 1'b1; halt = 1'b1; // RULE21
         end
         default: begin
            // Undefined codes fall through as a one-cycle no-operation
            case (op[7:3])
               `RIE_OP_BCLR: begin
                  res = mv & ~bmask; wm = 1'b1; // RULE17
               end
               `RIE_OP_BSET: begin
                  res = mv | bmask; wm = 1'b1; // RULE17
               end
               `RIE_OP_BSK0: skp = ~|(mv & bmask); // RULE18
               `RIE_OP_BSK1: skp = |(mv & bmask); // RULE18
               default: begin
                  jmp = (op[7:2] == `RIE_OP_JMP) | (op[7:2] == `RIE_OP_CALL); // RULE3
                  push = (op[7:2] == `RIE_OP_CALL); // RULE3
               end
            endcase
         end
      endcase
   end

   // ----------------------------------------
   // Program flow
   // ----------------------------------------
   // A two-cycle instruction leaves a bubble that swallows the next
   // instruction cycle, so every slow case costs exactly one more cycle
   always @* begin
      pc1 = pc + 10'h001;
      next_pc = pc1; // RULE26
      if (jmp)
         next_pc = inst[9:0]; // RULE3
      else if (pop)
         next_pc = stk0; // RULE3
      else if (skp)
         next_pc = pc + 10'h002; // RULE1
      else if (pcl_wr)
         next_pc = {pc1[9:8], res}; // RULE2
      next_bubble = jmp | pop | skp | tbl | pcl_wr; // RULE1 RULE2 RULE3 RULE4
   end

   // ----------------------------------------
   // Sequential state, execute and bus
   // ----------------------------------------
   always @(posedge mclk) begin
      if (!rst_b) begin
         pc <= `RIE_PC_RST;
         stk0 <= `RIE_PC_RST;
         stk1 <= `RIE_PC_RST;
         phase <= 2'h0;
         bubble <= 1'b0;
         run <= 1'b0;
         work_register <= 8'h00;
         table_upper_byte <= 8'h00;
         tbl_ptr <= 8'h00;
         tbl_page <= 8'h00;
         carry_flag <= 1'b0;
         half_carry_flag <= 1'b0;
         zero_flag <= 1'b0;
         signed_range_flag <= 1'b0;
         sleep_entered_flag <= 1'b0;
         wdt_expiry_flag <= 1'b0;
         master_irq_enable <= 1'b0;
         pm_ptr <= 10'h000;
         dm_ptr <= 5'h00;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         wdt_clear <= 1'b0;
         sleep <= 1'b0;
      end else begin
         wb_ack_o <= bus;
         wdt_clear <= 1'b0;
         if (run & ~sleep)
            phase <= phase + 2'h1; // RULE25
         if (exe & bubble)
            bubble <= 1'b0;
         if (exe & ~bubble) begin
            pc <= next_pc;
            bubble <= next_bubble;
            if (push) begin
               stk1 <= stk0;
               stk0 <= pc1;
            end
            if (pop)
               stk0 <= stk1;
            if (iret)
               master_irq_enable <= 1'b1; // RULE24
            if (tbl)
               table_upper_byte <= tword[15:8]; // RULE4 RULE5
            if (wa)
               work_register <= res;
            if (wm) begin
               case (ma)
                  `RIE_M_TBLP: tbl_ptr <= res;
                  `RIE_M_TBPG: tbl_page <= res;
                  `RIE_M_INTC: master_irq_enable <= res[0];
                  `RIE_M_STAT: begin
                     carry_flag <= res[`RIE_F_C];
                     half_carry_flag <= res[`RIE_F_HC];
                     zero_flag <= res[`RIE_F_Z];
                     signed_range_flag <= res[`RIE_F_SR];
                  end
                  `RIE_M_PCLOW, `RIE_M_TUB: ;
                  default: dmem[ma] <= res;
               endcase
            end
            // Flag updates come after the store so they win over it
            if (uz)
               zero_flag <= (res == 8'h00);
            if (uc)
               carry_flag <= uao ? s9[8] : nc;
            if (uao) begin
               half_carry_flag <= s5[4];
               signed_range_flag <= (work_register[7] == bb[7]) & (s9[7] != work_register[7]);
            end
            if (kick) begin
               wdt_clear <= 1'b1; // RULE23
               wdt_expiry_flag <= 1'b0; // RULE21 RULE23
               sleep_entered_flag <= halt; // RULE21 RULE23
            end
            if (halt) begin
               sleep <= 1'b1; // RULE21
               phase <= 2'h0;
            end
         end
         // An expiry in the same cycle as a clear still sets the flag
         if (wdt_expired)
            wdt_expiry_flag <= 1'b1;
         if (bus) begin
            wb_dat_o <= 32'h0000_0000;
            case (wb_adr_i)
               `RIE_A_CTRL: begin
                  wb_dat_o <= {31'h0, run};
                  if (wb_we_i & wb_sel_i[0]) begin
                     run <= wb_dat_i[`RIE_CTRL_RUN];
                     if (wb_dat_i[`RIE_CTRL_WAKE])
                        sleep <= 1'b0;
                     if (!wb_dat_i[`RIE_CTRL_RUN])
                        phase <= 2'h0;
                  end
               end
               `RIE_A_STAT:
                  wb_dat_o <= {5'h00, sleep, pc, stat_byte, work_register};
               `RIE_A_PMADR: begin
                  wb_dat_o <= {22'h0, pm_ptr};
                  if (wb_we_i & ~run & wb_sel_i[0])
                     pm_ptr[7:0] <= wb_dat_i[7:0];
                  if (wb_we_i & ~run & wb_sel_i[1])
                     pm_ptr[9:8] <= wb_dat_i[9:8];
               end
               `RIE_A_PMDAT: begin
                  wb_dat_o <= {16'h0, pmem[pm_ptr]};
                  // Loading is allowed only while stopped, to keep fetch stable
                  if (wb_we_i & ~run & (&wb_sel_i[1:0])) begin
                     pmem[pm_ptr] <= wb_dat_i[15:0];
                     pm_ptr <= pm_ptr + 10'h001;
                  end
               end
               `RIE_A_DMADR: begin
                  wb_dat_o <= {27'h0, dm_ptr};
                  if (wb_we_i & wb_sel_i[0])
                     dm_ptr <= wb_dat_i[4:0];
               end
               `RIE_A_DMDAT: begin
                  wb_dat_o <= {24'h0, rdm};
                  if (wb_we_i & ~run & wb_sel_i[0])
                     dmem[dm_ptr] <= wb_dat_i[7:0];
               end
               default: ;
            endcase
         end
      end
   end

endmodule

// ==== verification/rie_core_assertions.sv ====
// Purpose: port checker for rie_core
// Assumes: single mclk domain, rst_b low quiets every check
// Notes: bound to each rie_core instance at the foot of this file
`timescale 1ns/1ps
module rie_core_chk (
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        wdt_expired,
   input wire logic        wdt_clear,
   input wire logic        sleep
);
   // ------------------------------
   // Checks
   // ------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   wire take   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire ctrl_w = take && wb_we_i && wb_adr_i == 8'h00;
   // Kicks belong to whole instruction cycles, so none can follow closer
   sequence s_quiet3;
      !wdt_clear [*3];
   endsequence
   a_ack_follow:    assert property (take |=> wb_ack_o) else $error("ack missing");
   a_ack_single:    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_cause:     assert property (wb_ack_o |-> $past(take)) else $error("ack unasked");
   a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i == 8'h20 |=>
      wb_dat_o == 32'h0) else $error("unmapped read not zero");
   a_clear_spacing: assert property (wdt_clear |=> s_quiet3)
      else $error("kick pulses too close");
   a_halt_clear:    assert property ($rose(sleep) |-> wdt_clear)
      else $error("power down without watchdog clear");
   a_sleep_hold:    assert property (sleep && !ctrl_w |=> sleep)
      else $error("sleep dropped without wake");
   a_wake_drop:     assert property (sleep && ctrl_w && wb_dat_i[1] |=> ##[0:1] !sleep)
      else $error("wake ignored");
endmodule

bind rie_core rie_core_chk rie_core_chk_inst (.mclk(mclk), .rst_b(rst_b),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .wdt_expired(wdt_expired), .wdt_clear(wdt_clear), .sleep(sleep));

// ==== verification/rie_wdt_model.sv ====
// Purpose: external watchdog stand-in
// Assumes: bench asks for expiries with fire
// Notes: one expiry pulse per fire cycle, a cycle late like a real counter
`timescale 1ns/1ps
module rie_wdt_model (
   input wire logic mclk,
   input wire logic fire,
   output logic     wdt_expired
);
   initial wdt_expired = 1'b0;
   always @(posedge mclk) begin
      wdt_expired <= fire;
   end
endmodule

// ==== verification/tb_rie_core.sv ====
// Purpose: self-checking bench for rie_core
// Assumes: 40 MHz mclk, Wishbone loads code while stopped
// Notes: instruction timing judged from spacing of kick pulses
`timescale 1ns/1ps
module tb_rie_core;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic [31:0] rd;
   logic        wb_ack_o, wdt_expired, wdt_clear, sleep;
   logic        fire = 1'b0;
   int          bad_count = 0;
   int          n_tests = 0;
   int          cyc_n = 0;
   int          kicks[$];
   always #12.5 mclk = ~mclk;
   rie_core rie_core_inst (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .wdt_expired(wdt_expired), .wdt_clear(wdt_clear), .sleep(sleep));
   rie_wdt_model rie_wdt_model_inst (.mclk(mclk), .fire(fire), .wdt_expired(wdt_expired));
   // ------------------------------
   // Helpers
   // ------------------------------
   always @(posedge mclk) begin
      cyc_n <= cyc_n + 1;
      if (wdt_clear === 1'b1)
         kicks.push_back(cyc_n);
      if (cyc_n == 20000) begin
         bad_count++;
         wrap_up;
      end
   end
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_sel_i <= 4'hF;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic pw(input logic [31:0] a, input logic [31:0] v);
      bus(1'b1, 8'h08, a);
      bus(1'b1, 8'h0C, v);
   endtask
   task automatic dw(input logic [31:0] a, input logic [31:0] v);
      bus(1'b1, 8'h10, a);
      bus(1'b1, 8'h14, v);
   endtask
   task automatic dr(input logic [31:0] a);
      bus(1'b1, 8'h10, a);
      bus(1'b0, 8'h14, 0);
   endtask
   task automatic do_reset;
      rst_b <= 1'b0;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   // Kick, taken skip, kick, untaken skip, kick, jump, kick, then add and store
   task automatic t_flow;
      logic [15:0] prog [13] = '{16'h0300, 16'h3406, 16'h0000, 16'h0300, 16'h3407,
         16'h0300, 16'hF008, 16'h0000, 16'h0300, 16'h453A, 16'h40C8, 16'h3109, 16'hF00C};
      for (int i = 0; i < 13; i++)
         pw(i, prog[i]);
      dw(6, 0);
      dw(7, 5);
      kicks.delete();
      bus(1'b1, 8'h00, 1);
      repeat (80) @(posedge mclk);
      bus(1'b1, 8'h00, 0);
      chk(kicks[1] - kicks[0], 12);
      chk(kicks[2] - kicks[1], 8);
      chk(kicks[3] - kicks[2], 12);
      bus(1'b0, 8'h04, 0);
      chk(rd[15:0], 16'h0302);
      bus(1'b1, 8'h10, 9);
      bus(1'b0, 8'h14, 0);
      chk(rd[7:0], 8'h02);
      bus(1'b1, 8'h20, 32'h55);
      bus(1'b0, 8'h20, 0);
      chk(rd, 32'h0);
   endtask
   // Expiry sets its flag; power-down clears it, sets sleep, wake ends it
   task automatic t_halt;
      pw(0, 16'h0400);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      bus(1'b0, 8'h04, 0);
      chk(rd[15:8], 8'h20);
      bus(1'b1, 8'h00, 1);
      repeat (8) @(posedge mclk);
      chk(sleep, 1'b1);
      bus(1'b0, 8'h04, 0);
      chk(rd[15:8], 8'h10);
      chk(rd[26], 1'b1);
      bus(1'b1, 8'h00, 2);
      @(posedge mclk);
      chk(sleep, 1'b0);
   endtask
   // Decimal adjust, borrow subtract, bit and rotate ops, table read, pc low jump
   task automatic t_ops;
      logic [15:0] prog [18] = '{16'h4558, 16'h4067, 16'h1806, 16'h1606, 16'h5707,
         16'h2807, 16'h2E07, 16'h4511, 16'h3100, 16'h0300, 16'h3A08, 16'h0300,
         16'h4510, 16'h3102, 16'h0000, 16'h0000, 16'h0300, 16'hF011};
      for (int i = 0; i < 18; i++)
         pw(i, prog[i]);
      dw(7, 4);
      kicks.delete();
      bus(1'b1, 8'h00, 1);
      repeat (100) @(posedge mclk);
      bus(1'b1, 8'h00, 0);
      chk(kicks[1] - kicks[0], 12);
      chk(kicks[2] - kicks[1], 16);
      bus(1'b0, 8'h04, 0);
      chk(rd[15:0], 16'h0210);
      dr(6);
      chk(rd[7:0], 8'h25);
      dr(7);
      chk(rd[7:0], 8'h2C);
      dr(8);
      chk(rd[7:0], 8'h11);
   endtask
   initial begin
      do_reset;
      t_flow;
      do_reset;
      t_halt;
      do_reset;
      t_ops;
      wrap_up;
   end
endmodule
